// >>> rtl/rsrs_pkg.sv
/*
  Constants of the radio setup register slice: SPI command codes, register
  offsets, field positions, reset values and retry timing.
  Assumes a 50 MHz core clock and an SPI master running in mode 0.
*/
package rsrs_pkg;

  // ****************************************************************
  // Clock and timing.
  // ****************************************************************
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned RETRY_STEP_US   = 250;
  localparam int unsigned RETRY_STEP_CYC  = RETRY_STEP_US * (CLK_HZ / 1_000_000);

  // ****************************************************************
  // SPI commands.
  // ****************************************************************
  localparam logic [2:0] CMD_READ_TOP     = 3'h0;
  localparam logic [2:0] CMD_WRITE_TOP    = 3'h1;
  localparam logic [7:0] CMD_BANK_TOGGLE  = 8'h50;
  localparam logic [7:0] BANK_TOGGLE_KEY  = 8'h53;

  // ****************************************************************
  // Register offsets.
  // ****************************************************************
  localparam logic [4:0] OFS_ADDR_WIDTH   = 5'h03;
  localparam logic [4:0] OFS_RETRANSMIT   = 5'h04;
  localparam logic [4:0] OFS_CHANNEL      = 5'h05;
  localparam logic [4:0] OFS_RADIO_SETUP  = 5'h06;
  localparam logic [4:0] OFS_STATUS       = 5'h07;

  // ****************************************************************
  // Field positions and writable masks.
  // ****************************************************************
  localparam logic [7:0] MASK_ADDR_WIDTH  = 8'h03;
  localparam logic [7:0] MASK_CHANNEL     = 8'h7f;
  localparam logic [7:0] MASK_RADIO_SETUP = 8'h3f;
  localparam int unsigned POS_DELAY_LSB   = 4;
  localparam int unsigned POS_RATE_LOW    = 5;
  localparam int unsigned POS_LOCK_FORCE  = 4;
  localparam int unsigned POS_RATE_HIGH   = 3;
  localparam int unsigned POS_POWER_LSB   = 1;
  localparam int unsigned POS_GAIN_HIGH   = 0;
  localparam int unsigned POS_BANK        = 7;

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [7:0] RST_ADDR_WIDTH   = 8'h03;
  localparam logic [7:0] RST_RETRANSMIT   = 8'h03;
  localparam logic [7:0] RST_CHANNEL      = 8'h02;
  localparam logic [7:0] RST_RADIO_SETUP  = 8'h0f;

  // ****************************************************************
  // Address width codes and air rates.
  // ****************************************************************
  localparam logic [1:0] AW_3_BYTES       = 2'h1;
  localparam logic [1:0] AW_4_BYTES       = 2'h2;

  typedef enum logic [1:0] {
    RSRS_RATE_1M,
    RSRS_RATE_2M,
    RSRS_RATE_250K
  } rsrs_rate_e;

endpackage

// >>> rtl/rsrs_sync.sv
/*
  Two-flop synchroniser for a group of asynchronous pin inputs.
  Assumes the inputs change slowly compared with clk; each bit is
  synchronised on its own, so no multi-bit coherence is implied.
*/
`timescale 1ns/1ns
module rsrs_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,   // Core clock.
  input  wire logic             rst,   // Asynchronous reset, active high.
  input  wire logic [WIDTH-1:0] async_i, // Pin levels.
  output logic      [WIDTH-1:0] sync_o   // Synchronised levels.
);

  logic [WIDTH-1:0] meta_q;

  initial begin
    if (WIDTH < 1) begin
      $error("rsrs_sync: WIDTH must be at least 1.");
    end
  end

  // Reset to all ones so an idle high chip select stays deselected.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '1;
      sync_o <= '1;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

// >>> rtl/rsrs_top.sv
/*
  Radio setup register slice: address width, retransmission setup, channel,
  radio setup and the bank bit of the status register, reached over a
  four-wire SPI slave port (mode 0, MSB first).
  Assumes SCK at most 8 MHz against a 50 MHz clk so that every SCK phase
  spans several clk cycles after the two-flop synchronisers.
*/
// Functional notes
// R1: Width code 01/10/11 gives 3/4/5 address bytes; 00 illegal; reset is five.
// R2: Widths under five bytes keep only the least significant address bytes.
// R3: Retry delay code gives 250 us per step, 250 to 4000 us.
// R4: Retry count limits retransmissions; zero disables; reset allows three.
// R5: Seven-bit channel in bits 6:0, reset 0000010, bit 7 reserved.
// R6: Rate bits low,high: 00 1M, 01 2M reset, 10 250K, 11 2M.
// R7: Power code in bits 2:1 selects -10,-5,0,5 dBm; resets highest.
// R8: Bit 4 of radio setup forces lock indication; resets zero, test only.
// R9: Status byte shifts out on MISO while the command byte shifts in.
// R10: Status bit 7 is read-only, shows the active bank, resets zero.
// R11: Toggle command followed by 0x53 flips the bank and status bit.
// R12: Host writes zeros to reserved bits; device ignores other values.
`timescale 1ns/1ns
module rsrs_top
  import rsrs_pkg::*;
#(
  parameter int unsigned STEP_CYC = rsrs_pkg::RETRY_STEP_CYC
) (
  input  wire logic             clk,              // Core clock, 50 MHz.
  input  wire logic             rst,              // Asynchronous reset, active high.
  input  wire logic             spi_sck,          // SPI clock pin.
  input  wire logic             spi_csn_n,        // SPI chip select pin, active low.
  input  wire logic             spi_mosi,         // SPI data in pin.
  output logic                  spi_miso,         // SPI data out.
  output logic                  spi_miso_oe,      // MISO drive enable.
  input  wire logic [6:0]       status_low,       // Status bits 6:0 from neighbouring logic.
  input  wire logic [39:0]      stored_addr,      // Full five-byte stored address.
  output logic      [39:0]      active_addr,      // Address trimmed to configured width.
  output logic      [1:0]       address_byte_count, // Address width code.
  output logic      [3:0]       retry_delay_code, // Retransmission delay code.
  output logic      [17:0]      retry_wait_cycles,// Retransmission wait in clk cycles.
  output logic      [3:0]       retry_limit,      // Retransmission count limit.
  output logic                  retry_enable,     // Retransmission allowed.
  output logic      [6:0]       radio_channel,    // Channel number.
  output logic                  air_rate_low_bit, // Rate select low bit.
  output logic                  air_rate_high_bit,// Rate select high bit.
  output rsrs_pkg::rsrs_rate_e  air_rate,         // Decoded air rate.
  output logic                  lock_force,       // Force synthesizer lock indication.
  output logic      [1:0]       tx_power_level,   // Transmit power code.
  output logic                  receiver_gain_high, // High receiver gain.
  output logic                  bank_select_state // Active register bank.
);

  // ****************************************************************
  // Pin synchronisation.
  // ****************************************************************
  logic [2:0] pins_s;
  logic       sck_s, csn_s, mosi_s;

  rsrs_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk     (clk),
    .rst     (rst),
    .async_i ({spi_sck, spi_csn_n, spi_mosi}),
    .sync_o  (pins_s)
  );

  assign sck_s  = pins_s[2];
  assign csn_s  = pins_s[1];
  assign mosi_s = pins_s[0];

  initial begin
    if (STEP_CYC < 1 || STEP_CYC * 16 > 262143) begin
      $error("rsrs_top: STEP_CYC must be 1..16383.");
    end
  end

  // ****************************************************************
  // Edge detection on the synchronised pins.
  // ****************************************************************
  logic sck_prev_q, csn_prev_q;
  logic sck_rise, sck_fall, cs_start, selected;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sck_prev_q <= 1'b0;
      csn_prev_q <= 1'b1;
    end else begin
      sck_prev_q <= sck_s;
      csn_prev_q <= csn_s;
    end
  end

  assign selected = ~csn_s;
  assign sck_rise = selected & sck_s & ~sck_prev_q;
  assign sck_fall = selected & ~sck_s & sck_prev_q;
  assign cs_start = csn_prev_q & ~csn_s;

  // ****************************************************************
  // Registers.
  // ****************************************************************
  logic [7:0] aw_q, retr_q, chan_q, setup_q;
  logic       bank_q;
  logic [7:0] status_byte;

  assign status_byte = {bank_q, status_low}; // see R10

  // ****************************************************************
  // SPI receive side: bit counting, command capture, writes.
  // ****************************************************************
  logic [6:0] rx_q;
  logic [2:0] bit_q;
  logic       first_q;
  logic [7:0] cmd_q;
  logic [7:0] rx_byte;
  logic       byte_done, data_byte, wr_en, is_write;
  logic [4:0] wr_ofs;

  assign rx_byte   = {rx_q, mosi_s};
  assign byte_done = sck_rise & (bit_q == 3'h7);
  assign data_byte = byte_done & ~first_q;
  assign is_write  = (cmd_q[7:5] == CMD_WRITE_TOP);
  assign wr_ofs    = cmd_q[4:0];
  // Bank one holds other registers; this slice takes writes in bank zero only.
  assign wr_en     = data_byte & is_write & ~bank_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_q    <= 7'h00;
      bit_q   <= 3'h0;
      first_q <= 1'b1;
      cmd_q   <= 8'hff;
    end else if (!selected) begin
      bit_q   <= 3'h0;
      first_q <= 1'b1;
    end else if (sck_rise) begin
      rx_q  <= rx_byte[6:0];
      bit_q <= bit_q + 3'h1;
      if (bit_q == 3'h7 && first_q) begin
        cmd_q   <= rx_byte;
        first_q <= 1'b0;
      end
    end
  end

  // Reserved bits are masked away on write, so they always read zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_q    <= RST_ADDR_WIDTH;   // see R1
      retr_q  <= RST_RETRANSMIT;   // see R4
      chan_q  <= RST_CHANNEL;      // see R5
      setup_q <= RST_RADIO_SETUP;  // see R6
    end else if (wr_en) begin
      case (wr_ofs)
        OFS_ADDR_WIDTH:  aw_q    <= rx_byte & MASK_ADDR_WIDTH;  // see R12
        OFS_RETRANSMIT:  retr_q  <= rx_byte;                    // see R3
        OFS_CHANNEL:     chan_q  <= rx_byte & MASK_CHANNEL;     // see R5
        OFS_RADIO_SETUP: setup_q <= rx_byte & MASK_RADIO_SETUP; // see R12
        default: begin
        end
      endcase
    end
  end

  // The key byte may be any byte after the command byte in the same chip-select frame.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bank_q <= 1'b0;
    end else if (data_byte && cmd_q == CMD_BANK_TOGGLE && rx_byte == BANK_TOGGLE_KEY) begin
      bank_q <= ~bank_q; // see R11
    end
  end

  // ****************************************************************
  // SPI transmit side.
  // ****************************************************************
  logic [7:0] rd_data, tx_q;
  logic [4:0] rd_ofs;

  // On the command byte the read offset comes from the byte just received.
  assign rd_ofs = first_q ? rx_byte[4:0] : cmd_q[4:0];

  always_comb begin
    rd_data = 8'h00;
    if (bank_q == 1'b0 || rd_ofs == OFS_STATUS) begin
      case (rd_ofs)
        OFS_ADDR_WIDTH:  rd_data = aw_q;
        OFS_RETRANSMIT:  rd_data = retr_q;
        OFS_CHANNEL:     rd_data = chan_q;
        OFS_RADIO_SETUP: rd_data = setup_q;
        OFS_STATUS:      rd_data = status_byte;
        default:         rd_data = 8'h00;
      endcase
    end
  end

  logic rd_cmd;
  assign rd_cmd = first_q ? (rx_byte[7:5] == CMD_READ_TOP) : (cmd_q[7:5] == CMD_READ_TOP);

  // MISO changes on the falling SCK edge and is stable for the rising edge.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_q        <= 8'h00;
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso_oe <= selected;
      if (cs_start) begin
        spi_miso <= status_byte[7];             // see R9
        tx_q     <= {status_byte[6:0], 1'b0};   // see R9
      end else if (byte_done) begin
        tx_q <= rd_cmd ? rd_data : 8'h00;
      end else if (sck_fall) begin
        spi_miso <= tx_q[7];
        tx_q     <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // ****************************************************************
  // Decoded configuration outputs.
  // ****************************************************************
  logic [39:0] addr_mask;

  always_comb begin
    case (aw_q[1:0])
      AW_3_BYTES: addr_mask = 40'h00_00ff_ffff; // see R2
      AW_4_BYTES: addr_mask = 40'h00_ffff_ffff; // see R2
      default:    addr_mask = 40'hff_ffff_ffff;
    endcase
  end

  logic [17:0] wait_cyc;
  assign wait_cyc = 18'((retr_q[7:POS_DELAY_LSB] + 5'h01) * STEP_CYC); // see R3

  rsrs_rate_e rate_d;
  always_comb begin
    case ({setup_q[POS_RATE_LOW], setup_q[POS_RATE_HIGH]})
      2'h0:    rate_d = RSRS_RATE_1M;   // see R6
      2'h2:    rate_d = RSRS_RATE_250K; // see R6
      default: rate_d = RSRS_RATE_2M;   // see R6
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active_addr        <= 40'h00_0000_0000;
      address_byte_count <= RST_ADDR_WIDTH[1:0];
      retry_delay_code   <= RST_RETRANSMIT[7:4];
      retry_wait_cycles  <= 18'h00000;
      retry_limit        <= RST_RETRANSMIT[3:0];
      retry_enable       <= 1'b1;
      radio_channel      <= RST_CHANNEL[6:0];
      air_rate_low_bit   <= RST_RADIO_SETUP[POS_RATE_LOW];
      air_rate_high_bit  <= RST_RADIO_SETUP[POS_RATE_HIGH];
      air_rate           <= RSRS_RATE_2M;
      lock_force         <= RST_RADIO_SETUP[POS_LOCK_FORCE];
      tx_power_level     <= RST_RADIO_SETUP[2:1];
      receiver_gain_high <= RST_RADIO_SETUP[POS_GAIN_HIGH];
      bank_select_state  <= 1'b0;
    end else begin
      active_addr        <= stored_addr & addr_mask;           // see R2
      address_byte_count <= aw_q[1:0];                         // see R1
      retry_delay_code   <= retr_q[7:POS_DELAY_LSB];           // see R3
      retry_wait_cycles  <= wait_cyc;                          // see R3
      retry_limit        <= retr_q[3:0];                       // see R4
      retry_enable       <= (retr_q[3:0] != 4'h0);             // see R4
      radio_channel      <= chan_q[6:0];                       // see R5
      air_rate_low_bit   <= setup_q[POS_RATE_LOW];
      air_rate_high_bit  <= setup_q[POS_RATE_HIGH];
      air_rate           <= rate_d;
      lock_force         <= setup_q[POS_LOCK_FORCE];           // see R8
      tx_power_level     <= setup_q[POS_POWER_LSB +: 2];       // see R7
      receiver_gain_high <= setup_q[POS_GAIN_HIGH];
      bank_select_state  <= bank_q;                            // see R10
    end
  end

endmodule

// >>> verif/rsrs_checker.sv
/*
  Port checker for rsrs_top.
  Assumes one clk domain and attachment to rsrs_top by bind.
*/
`timescale 1ns/1ns
module rsrs_checker
  import rsrs_pkg::*;
#(
  parameter int unsigned STEP_CYC = 4
) (
  input wire logic                 clk,                // Core clock.
  input wire logic                 rst,                // Reset, active high.
  input wire logic                 spi_csn_n,          // Chip select, active low.
  input wire logic                 spi_miso_oe,        // MISO drive enable.
  input wire logic [39:0]          stored_addr,        // Stored address.
  input wire logic [39:0]          active_addr,        // Trimmed address.
  input wire logic [1:0]           address_byte_count, // Width code.
  input wire logic [3:0]           retry_delay_code,   // Delay code.
  input wire logic [17:0]          retry_wait_cycles,  // Wait in cycles.
  input wire logic [3:0]           retry_limit,        // Retry limit.
  input wire logic                 retry_enable,       // Retry allowed.
  input wire logic [6:0]           radio_channel,      // Channel.
  input wire logic                 air_rate_low_bit,   // Rate low bit.
  input wire logic                 air_rate_high_bit,  // Rate high bit.
  input wire rsrs_pkg::rsrs_rate_e air_rate,           // Decoded rate.
  input wire logic                 lock_force,         // Lock force.
  input wire logic [1:0]           tx_power_level,     // Power code.
  input wire logic                 bank_select_state   // Active bank.
);
  // ****************************************************************
  // Helper logic.
  // ****************************************************************
  // Counts the first cycles after reset, when registered values are still settling.
  logic [1:0] up_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  function automatic logic [39:0] trim(input logic [1:0] w, input logic [39:0] a);
    case (w)
      2'h1: trim = {16'h0, a[23:0]};
      2'h2: trim = {8'h0, a[31:0]};
      default: trim = a;
    endcase
  endfunction
  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_rate;
    air_rate == (air_rate_high_bit ? RSRS_RATE_2M :
                 (air_rate_low_bit ? RSRS_RATE_250K : RSRS_RATE_1M));
  endproperty
  a_rate: assert property (p_rate) else $error("air rate decode wrong");
  property p_retry_en;
    retry_enable == (retry_limit != 4'h0);
  endproperty
  a_retry_en: assert property (p_retry_en) else $error("retry enable wrong");
  property p_wait;
    (up_q == 2'h3) && $stable(retry_delay_code) |->
      retry_wait_cycles == (18'(retry_delay_code) + 18'h1) * 18'(STEP_CYC);
  endproperty
  a_wait: assert property (p_wait) else $error("retry wait wrong");
  property p_addr;
    (up_q == 2'h3) && $stable(address_byte_count) |->
      active_addr == trim(address_byte_count, $past(stored_addr));
  endproperty
  a_addr: assert property (p_addr) else $error("address trim wrong");
  property p_oe_off;
    spi_csn_n [*5] |-> !spi_miso_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("MISO driven while idle");
  property p_oe_on;
    !spi_csn_n [*5] |-> spi_miso_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("MISO not driven in frame");
  property p_quiet;
    (up_q == 2'h3) && spi_csn_n [*8] |->
      $stable(radio_channel) && $stable(bank_select_state) && $stable(lock_force);
  endproperty
  a_quiet: assert property (p_quiet) else $error("setting changed while idle");
  property p_reset;
    up_q == 2'h1 |-> address_byte_count == 2'h3 && retry_limit == 4'h3 &&
      radio_channel == 7'h02 && tx_power_level == 2'h3 && !lock_force && !bank_select_state;
  endproperty
  a_reset: assert property (p_reset) else $error("reset value wrong");
endmodule

bind rsrs_top rsrs_checker #(.STEP_CYC(STEP_CYC)) u_rsrs_checker (
  .clk(clk), .rst(rst), .spi_csn_n(spi_csn_n), .spi_miso_oe(spi_miso_oe),
  .stored_addr(stored_addr), .active_addr(active_addr),
  .address_byte_count(address_byte_count), .retry_delay_code(retry_delay_code),
  .retry_wait_cycles(retry_wait_cycles), .retry_limit(retry_limit),
  .retry_enable(retry_enable), .radio_channel(radio_channel),
  .air_rate_low_bit(air_rate_low_bit), .air_rate_high_bit(air_rate_high_bit),
  .air_rate(air_rate), .lock_force(lock_force), .tx_power_level(tx_power_level),
  .bank_select_state(bank_select_state)
);

// >>> verif/rsrs_host_model.sv
/*
  Host SPI master model, mode 0, MSB first, half period of six clk cycles.
  Assumes the device drives MISO only while its enable is high.
*/
`timescale 1ns/1ns
module rsrs_host_model
  import rsrs_pkg::*;
(
  input  wire logic clk,         // Core clock, paces the SPI timing.
  output logic      spi_sck,     // SPI clock.
  output logic      spi_csn_n,   // Chip select, active low.
  output logic      spi_mosi,    // Data to the device.
  input  wire logic spi_miso,    // Data from the device.
  input  wire logic spi_miso_oe  // Device drive enable.
);
  // A released line shows the inverse of its last level, so a sample taken too early shows up.
  wire miso_w = spi_miso_oe ? spi_miso : ~spi_miso;
  initial begin
    spi_sck = 1'b0;
    spi_csn_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // ****************************************************************
  // Frames.
  // ****************************************************************
  task automatic frame(input logic [7:0] b0, input logic [7:0] b1,
                       output logic [7:0] r0, output logic [7:0] r1);
    logic [15:0] tx;
    logic [15:0] rx;
    tx = {b0, b1};
    @(posedge clk);
    #1 spi_csn_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi = tx[i];
      repeat (6) @(posedge clk);
      #1 rx[i] = miso_w;
      spi_sck = 1'b1;
      repeat (6) @(posedge clk);
      #1 spi_sck = 1'b0;
    end
    repeat (6) @(posedge clk);
    // A deselected input shows no stale level.
    #1 spi_csn_n = 1'b1;
    spi_mosi = ~spi_mosi;
    r0 = rx[15:8];
    r1 = rx[7:0];
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d, output logic [7:0] st);
    logic [7:0] m;
    logic [7:0] r;
    case (a)
      OFS_ADDR_WIDTH: m = 8'h03;
      OFS_CHANNEL: m = 8'h7f;
      OFS_RADIO_SETUP: m = 8'h3f;
      default: m = 8'hff;
    endcase
    frame({CMD_WRITE_TOP, a}, d & m, st, r);
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] st, output logic [7:0] d);
    frame({CMD_READ_TOP, a}, 8'h00, st, d);
  endtask
  task automatic tog(output logic [7:0] st);
    logic [7:0] r;
    frame(CMD_BANK_TOGGLE, BANK_TOGGLE_KEY, st, r);
  endtask
endmodule

// >>> verif/rsrs_top_tb.sv
/*
  Self-checking bench for rsrs_top with the host model on the SPI pins.
  Assumes a 50 MHz clock and a shortened retry step.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
  $display("FAIL %0t got %h exp %h", $time, (a), (b)); end end
module rsrs_top_tb;
  import rsrs_pkg::*;
  localparam int unsigned STEP = 4;
  logic        clk, rst, spi_sck, spi_csn_n, spi_mosi, spi_miso, spi_miso_oe;
  logic [6:0]  status_low, radio_channel;
  logic [39:0] stored_addr, active_addr, ex;
  logic [1:0]  address_byte_count, tx_power_level;
  logic [3:0]  retry_delay_code, retry_limit;
  logic [17:0] retry_wait_cycles;
  logic        retry_enable, air_rate_low_bit, air_rate_high_bit, lock_force;
  logic        receiver_gain_high, bank_select_state;
  rsrs_rate_e  air_rate;
  logic [7:0]  st, d;
  int          errors, compares, cyc;
  rsrs_top #(.STEP_CYC(STEP)) u_rsrs_top (.clk(clk), .rst(rst), .spi_sck(spi_sck),
    .spi_csn_n(spi_csn_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .status_low(status_low), .stored_addr(stored_addr),
    .active_addr(active_addr), .address_byte_count(address_byte_count),
    .retry_delay_code(retry_delay_code), .retry_wait_cycles(retry_wait_cycles),
    .retry_limit(retry_limit), .retry_enable(retry_enable), .radio_channel(radio_channel),
    .air_rate_low_bit(air_rate_low_bit), .air_rate_high_bit(air_rate_high_bit),
    .air_rate(air_rate), .lock_force(lock_force), .tx_power_level(tx_power_level),
    .receiver_gain_high(receiver_gain_high), .bank_select_state(bank_select_state));
  rsrs_host_model u_rsrs_host_model (.clk(clk), .spi_sck(spi_sck), .spi_csn_n(spi_csn_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));
  initial clk = 1'b0;
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end
  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_reset;
    `CHK(address_byte_count, 2'h3)
    `CHK({retry_delay_code, retry_wait_cycles}, {4'h0, 18'(STEP)})
    `CHK({retry_limit, retry_enable}, 5'h07)
    `CHK(radio_channel, 7'h02)
    `CHK({air_rate_low_bit, air_rate_high_bit, air_rate}, {2'b01, RSRS_RATE_2M})
    `CHK({lock_force, tx_power_level, receiver_gain_high}, 4'h7)
    u_rsrs_host_model.rd(OFS_CHANNEL, st, d);
    `CHK(st, {1'b0, status_low})
    `CHK(d, 8'h02)
  endtask
  task automatic t_width;
    for (int w = 1; w <= 3; w++) begin
      u_rsrs_host_model.wr(OFS_ADDR_WIDTH, 8'(w), st);
      stored_addr = stored_addr + 40'h1111111111;
      repeat (2) @(posedge clk);
      #1 ex = (w == 1) ? {16'h0, stored_addr[23:0]} :
              (w == 2) ? {8'h0, stored_addr[31:0]} : stored_addr;
      `CHK(active_addr, ex)
      u_rsrs_host_model.rd(OFS_ADDR_WIDTH, st, d);
      `CHK({address_byte_count, d}, {2'(w), 8'(w)})
    end
  endtask
  task automatic t_retry;
    u_rsrs_host_model.wr(OFS_RETRANSMIT, 8'hf0, st);
    `CHK({retry_delay_code, retry_limit, retry_enable}, 9'h1e0)
    `CHK(retry_wait_cycles, 18'(16 * STEP))
    u_rsrs_host_model.wr(OFS_RETRANSMIT, 8'h5f, st);
    `CHK({retry_delay_code, retry_limit, retry_enable}, 9'h0bf)
    `CHK(retry_wait_cycles, 18'(6 * STEP))
  endtask
  task automatic t_chan;
    u_rsrs_host_model.wr(OFS_CHANNEL, 8'h7f, st);
    u_rsrs_host_model.rd(OFS_CHANNEL, st, d);
    `CHK({radio_channel, d}, {7'h7f, 8'h7f})
  endtask
  task automatic t_setup;
    rsrs_rate_e tab [4];
    logic [1:0] c;
    tab = '{RSRS_RATE_1M, RSRS_RATE_2M, RSRS_RATE_250K, RSRS_RATE_2M};
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      u_rsrs_host_model.wr(OFS_RADIO_SETUP, {2'b00, c[1], 1'b0, c[0], c, ~c[0]}, st);
      `CHK({air_rate_low_bit, air_rate_high_bit, air_rate}, {c, tab[i]})
      `CHK({tx_power_level, receiver_gain_high}, {c, ~c[0]})
    end
    u_rsrs_host_model.wr(OFS_RADIO_SETUP, 8'h1f, st);
    `CHK(lock_force, 1'b1)
    u_rsrs_host_model.wr(OFS_RADIO_SETUP, 8'h0f, st);
    `CHK(lock_force, 1'b0)
  endtask
  task automatic t_bank;
    u_rsrs_host_model.wr(OFS_STATUS, 8'h80, st);
    `CHK(bank_select_state, 1'b0)
    u_rsrs_host_model.tog(st);
    `CHK({st[7], bank_select_state}, 2'b01)
    u_rsrs_host_model.wr(OFS_CHANNEL, 8'h11, st);
    `CHK({st, radio_channel}, {1'b1, status_low, 7'h7f})
    u_rsrs_host_model.rd(OFS_STATUS, st, d);
    `CHK({st, d}, {2{1'b1, status_low}})
    u_rsrs_host_model.rd(OFS_CHANNEL, st, d);
    `CHK(d, 8'h00)
    u_rsrs_host_model.tog(st);
    `CHK(bank_select_state, 1'b0)
    u_rsrs_host_model.rd(OFS_STATUS, st, d);
    `CHK({st, d}, {2{1'b0, status_low}})
  endtask
  task automatic summarize;
    if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    status_low = 7'h2a;
    stored_addr = 40'hc1c2c3c4c5;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    #1 t_reset();
    t_width();
    t_retry();
    t_chan();
    t_setup();
    t_bank();
    summarize();
  end
endmodule
